// *** bench/jpc_jtag_host.sv ***
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
module jpc_jtag_host (
  // bench clock
  input wire logic sys_clk,
  // port pins
  output logic tms,
  output logic tck,
  output logic tdi
);
  // link clock stands low between frames
  initial begin
    tms = 1'b1;
    tck = 1'b0;
    tdi = 1'b0;
  end
  // one 180 ns link clock: five system cycles low, four high
  task automatic tick(input logic m, input logic d);
    @(posedge sys_clk);
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge sys_clk);
    tck <= 1'b1;
    repeat (4) @(posedge sys_clk);
    tck <= 1'b0;
  endtask
  // walk from reset or idle through a shift state, lsb first, back to idle
  task automatic scan(input logic ir, input logic [21:0] v, input int n);
    int i;
    tick(1'b0, 1'b0);
    tick(1'b1, 1'b0);
    if (ir)
      tick(1'b1, 1'b0);
    tick(1'b0, 1'b0);
    tick(1'b0, 1'b0);
    for (i = 0; i < n; i++)
      tick(i == n - 1, v[i]);
    tick(1'b1, 1'b0);
    tick(1'b0, 1'b0);
  endtask
  // instruction then its data word
  task automatic cmd(input logic [3:0] ir, input logic [21:0] dr);
    scan(1'b1, {18'h0, ir}, 4);
    scan(1'b0, dr, 22);
  endtask
endmodule
`default_nettype wire

// *** bench/jpc_port_ctrl_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
module jpc_port_ctrl_chk #(
  parameter NSEC = 12
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // sources and flash side
  input wire logic nvm_dedicate,
  input wire logic flash_busy,
  input wire logic security_bit,
  input wire logic [NSEC-1:0] sector_protect,
  // design outputs
  input wire logic [6:0] port_c_out,
  input wire logic [6:0] port_c_oe,
  input wire logic port_owned,
  input wire logic flash_req,
  input wire logic [1:0] flash_op,
  input wire logic [3:0] flash_sector,
  input wire logic clear_security,
  input wire logic cmd_refused
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // four cycles allow for the source path latency
  chk_nvm_owns_port: assert property (nvm_dedicate [*4] |-> port_owned)
    else $error("dedicated source did not take the port");
  chk_released_pins: assert property (!port_owned |-> port_c_oe == 7'h00)
    else $error("pins driven while port released");
  chk_inputs_only: assert property (port_c_oe[5] == 1'b0 && port_c_oe[1:0] == 2'h0)
    else $error("input pin driven");
  chk_stat_busy: assert property (flash_busy [*3] ##0 port_c_oe[3] |-> !port_c_out[3])
    else $error("status high while flash busy");
  chk_secure_block: assert property (flash_req && security_bit |-> flash_op == 2'h3)
    else $error("secured device let a command through");
  chk_chip_clear: assert property (clear_security |-> flash_req && flash_op == 2'h3)
    else $error("security cleared without chip erase");
  chk_protect_erase: assert property (flash_req && flash_op == 2'h2 |-> !sector_protect[flash_sector])
    else $error("protected sector erased");
  chk_req_single: assert property (flash_req |=> !flash_req && !cmd_refused)
    else $error("flash request longer than one cycle");
  // main scenarios
  cov_req: cover property (flash_req && flash_op == 2'h1);
  cov_refused: cover property (cmd_refused);
  cov_clear: cover property (clear_security);
endmodule
bind jpc_port_ctrl jpc_port_ctrl_chk #(.NSEC(NSEC)) jpc_port_ctrl_chk_inst (
  .sys_clk, .nrst, .nvm_dedicate, .flash_busy, .security_bit, .sector_protect,
  .port_c_out, .port_c_oe, .port_owned, .flash_req, .flash_op, .flash_sector,
  .clear_security, .cmd_refused);
`default_nettype wire

// *** bench/jpc_port_ctrl_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "jpc_map.vh"
////////////////////////////////////////////////////////////////////////
module jpc_port_ctrl_tb;
  logic sys_clk, nrst, dev_rst_n, nvm_dedicate, port_select_term;
  logic blank_device, reg_wr, flash_busy, flash_fail, security_bit, clr_seen;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [6:0] pin_in, port_c_out, port_c_oe;
  logic port_owned, flash_req, clear_security, cmd_refused;
  logic [1:0] flash_op;
  logic [3:0] flash_sector;
  logic [11:0] sector_protect;
  logic [6:0] note_q[$];
  logic [31:0] rnd_q;
  wire tms, tck, tdi;
  int err_count, n_checks;
  // host owns mode, clock, data in; the rest are pulled high when released
  always_comb begin
    for (int i = 0; i < 7; i++)
      pin_in[i] = port_c_oe[i] ? port_c_out[i] : 1'b1;
    pin_in[0] = tms;
    pin_in[1] = tck;
    pin_in[5] = tdi;
  end
  jpc_jtag_host jpc_jtag_host_inst (.sys_clk(sys_clk), .tms(tms), .tck(tck),
    .tdi(tdi));
  jpc_port_ctrl #(.NSEC(12)) jpc_port_ctrl_inst (.sys_clk(sys_clk),
    .nrst(nrst), .dev_rst_n(dev_rst_n), .nvm_dedicate(nvm_dedicate),
    .port_select_term(port_select_term), .blank_device(blank_device),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .port_c_in(pin_in), .port_c_out(port_c_out),
    .port_c_oe(port_c_oe), .port_owned(port_owned), .flash_busy(flash_busy),
    .flash2_writing(1'b0), .flash_fail(flash_fail),
    .security_bit(security_bit), .sector_protect(sector_protect),
    .flash_rdata(8'h00), .flash_req(flash_req), .flash_op(flash_op),
    .flash_sector(flash_sector), .flash_addr(), .flash_wdata(),
    .clear_security(clear_security), .cmd_refused(cmd_refused));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    if (err_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask
  // one flash command; top note bit set means a refusal, 7F means no result
  task automatic op(input logic [3:0] ir, input logic [1:0] o,
                    input logic [6:0] exp);
    rnd_q = xs(rnd_q);
    if (exp != 7'h7F)
      note_q.push_back(exp);
    jpc_jtag_host_inst.cmd(ir, {o, exp[3:0], rnd_q[15:0]});
    repeat (8) @(posedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // results are compared in order against the notes
  always @(posedge sys_clk) begin
    if (clear_security === 1'b1)
      clr_seen <= 1'b1;
    if (flash_req === 1'b1 || cmd_refused === 1'b1) begin
      if (note_q.size() == 0)
        check(8'hEE, 8'h00);
      else if (note_q[0][6])
        check(cmd_refused, 1'b1);
      else
        check({cmd_refused, flash_op, flash_sector}, note_q[0]);
      if (note_q.size() != 0)
        void'(note_q.pop_front());
    end
  end
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    #500000;
    err_count++;
    test_done();
  end
  initial begin
    {nrst, nvm_dedicate, port_select_term, blank_device} = 4'h0;
    {reg_wr, flash_busy, flash_fail, security_bit, clr_seen} = 5'h00;
    dev_rst_n = 1'b1;
    reg_addr = `JPC_REG_RUNTIME_EN;
    reg_wdata = 8'h00;
    sector_protect = 12'h000;
    rnd_q = 32'h00013012; // seed 77842
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (6) @(posedge sys_clk);
    check(port_owned, 1'b0);
    wr(8'h01);
    check(port_owned, 1'b1);
    check(reg_rdata, 8'h01);
    wr(8'h00);
    check(port_owned, 1'b0);
    wr(8'h01);
    // device reset held through a command blocks it
    dev_rst_n <= 1'b0;
    jpc_jtag_host_inst.cmd(`JPC_IR_ENABLE, 22'h1);
    op(`JPC_IR_PROGRAM, 2'h1, 7'h7F);
    dev_rst_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    check(port_owned, 1'b0);
    check(reg_rdata, 8'h00);
    blank_device <= 1'b1;
    repeat (6) @(posedge sys_clk);
    check(port_owned, 1'b1);
    blank_device <= 1'b0;
    port_select_term <= 1'b1;
    repeat (6) @(posedge sys_clk);
    check(port_owned, 1'b1);
    check({port_c_oe[6], port_c_oe[4:3]}, 8'h00);
    jpc_jtag_host_inst.cmd(`JPC_IR_ENABLE, 22'h1);
    repeat (6) @(posedge sys_clk);
    check({port_c_oe[3], port_c_out[3]}, 8'h03);
    flash_busy <= 1'b1;
    repeat (6) @(posedge sys_clk);
    check(port_c_out[3], 1'b0);
    flash_busy <= 1'b0;
    op(`JPC_IR_PROGRAM, 2'h1, {3'h1, rnd_q[2:0] & 4'h7});
    flash_fail <= 1'b1;
    @(posedge sys_clk);
    flash_fail <= 1'b0;
    repeat (6) @(posedge sys_clk);
    check(port_c_out[4], 1'b0);
    jpc_jtag_host_inst.cmd(`JPC_IR_CLEAR, 22'h0);
    repeat (6) @(posedge sys_clk);
    check(port_c_out[4], 1'b1);
    sector_protect <= 12'h004;
    op(`JPC_IR_ERASE, 2'h2, 7'h52);
    op(`JPC_IR_ERASE, 2'h2, 7'h23);
    security_bit <= 1'b1;
    op(`JPC_IR_READ, 2'h0, 7'h41);
    op(`JPC_IR_PROGRAM, 2'h1, 7'h51);
    op(`JPC_IR_CHIP_ERASE, 2'h3, 7'h30);
    check(clr_seen, 1'b1);
    security_bit <= 1'b0;
    port_select_term <= 1'b0;
    nvm_dedicate <= 1'b1;
    dev_rst_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    check(port_owned, 1'b1);
    jpc_jtag_host_inst.cmd(`JPC_IR_ENABLE, 22'h3);
    repeat (6) @(posedge sys_clk);
    check(port_c_oe[4], 1'b0);
    op(`JPC_IR_PROGRAM, 2'h1, 7'h15);
    test_done();
  end
endmodule
`default_nettype wire

// *** rtl/jpc_port_ctrl.v ***
// How it works
// - port is enabled when nvm bit, runtime bit or product term is set.
// - with port off, the four pins are released to general i/o.
// - pins are inputs until enable command; then data out drives.
// - runtime bit at offset C7h; reset or cpu write clears it.
// - nvm-dedicated port ignores device reset.
// - runtime-enabled port is blocked or aborted by device reset.
// - user product term is the third enable source.
// - blank device enables the four basic signals by default.
// - flash arrays, logic and config bits programmed over serial port.
// - configuration commands only; no boundary scan.
// - status and error outputs enabled only by the enable command.
// - error output goes low on failed erase or program.
// - error stays low until clear, or reset after disable.
// - status high while flash is in read mode.
// - status low during program, erase or secondary flash write.
// - enable option selects open-drain status and error drive.
// - secured device refuses read, verify, program and erase; chip erase, enable, disable and clear still run.
// - chip erase clears security and leaves device blank.
// - erase of a protected sector is rejected.
// - pins: mode pc0, clock pc1, status pc3, error pc4, in pc5, out pc6.
`timescale 1ns/1ps
`default_nettype none
`include "jpc_map.vh"
module jpc_port_ctrl #(
  parameter NSEC = 12
) (
  // clock and reset
  input wire sys_clk,
  input wire nrst,
  // device reset, active low, from the device pin
  input wire dev_rst_n,
  // enable sources
  input wire nvm_dedicate,
  input wire port_select_term,
  input wire blank_device,
  // cpu register port (offset above io_block_base)
  input wire reg_wr,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // port c pins, pc0..pc6
  input wire [6:0] port_c_in,
  output reg [6:0] port_c_out,
  output reg [6:0] port_c_oe,
  output reg port_owned,
  // flash side
  input wire flash_busy,
  input wire flash2_writing,
  input wire flash_fail,
  input wire security_bit,
  input wire [NSEC-1:0] sector_protect,
  input wire [7:0] flash_rdata,
  output reg flash_req,
  output reg [1:0] flash_op,
  output reg [3:0] flash_sector,
  output reg [7:0] flash_addr,
  output reg [7:0] flash_wdata,
  output reg clear_security,
  output reg cmd_refused
);
////////////////////////////////////////////////////////////////////////
// tap states
localparam S_RESET = 16'h0001;
localparam S_IDLE = 16'h0002;
localparam S_SDR = 16'h0004;
localparam S_CDR = 16'h0008;
localparam S_SHDR = 16'h0010;
localparam S_E1DR = 16'h0020;
localparam S_PDR = 16'h0040;
localparam S_E2DR = 16'h0080;
localparam S_UDR = 16'h0100;
localparam S_SIR = 16'h0200;
localparam S_CIR = 16'h0400;
localparam S_SHIR = 16'h0800;
localparam S_E1IR = 16'h1000;
localparam S_PIR = 16'h2000;
localparam S_E2IR = 16'h4000;
localparam S_UIR = 16'h8000;
// flash operation codes
localparam OP_READ = 2'h0;
localparam OP_PROG = 2'h1;
localparam OP_ERASE = 2'h2;
localparam OP_CHIP = 2'h3;

// next tap state from current state and mode bit
function [15:0] tap_next;
  input [15:0] s;
  input m;
  begin
    case (s)
      S_RESET: tap_next = m ? S_RESET : S_IDLE;
      S_IDLE: tap_next = m ? S_SDR : S_IDLE;
      S_SDR: tap_next = m ? S_SIR : S_CDR;
      S_CDR: tap_next = m ? S_E1DR : S_SHDR;
      S_SHDR: tap_next = m ? S_E1DR : S_SHDR;
      S_E1DR: tap_next = m ? S_UDR : S_PDR;
      S_PDR: tap_next = m ? S_E2DR : S_PDR;
      S_E2DR: tap_next = m ? S_UDR : S_SHDR;
      S_UDR: tap_next = m ? S_SDR : S_IDLE;
      S_SIR: tap_next = m ? S_RESET : S_CIR;
      S_CIR: tap_next = m ? S_E1IR : S_SHIR;
      S_SHIR: tap_next = m ? S_E1IR : S_SHIR;
      S_E1IR: tap_next = m ? S_UIR : S_PIR;
      S_PIR: tap_next = m ? S_E2IR : S_PIR;
      S_E2IR: tap_next = m ? S_UIR : S_SHIR;
      S_UIR: tap_next = m ? S_SDR : S_IDLE;
      default: tap_next = S_RESET;
    endcase
  end
endfunction

////////////////////////////////////////////////////////////////////////
// pin and reset synchronisers
wire [6:0] pc_s;
wire rst_n_s;
jpc_sync2 #(.W(8)) u_sync (
  .sys_clk(sys_clk),
  .nrst(nrst),
  .async_in({dev_rst_n, port_c_in}),
  .sync_out({rst_n_s, pc_s})
);
wire tms = pc_s[`JPC_PC_MODE];
wire tck = pc_s[`JPC_PC_CLK];
wire tdi = pc_s[`JPC_PC_DIN];

////////////////////////////////////////////////////////////////////////
// runtime enable register; a device reset or cpu write clears it
reg run_en_q;
reg rst_seen_q;
always @(posedge sys_clk) begin
  if (!nrst) begin
    run_en_q <= 1'b0;
  end else if (!rst_n_s) begin
    run_en_q <= 1'b0;
  end else if (reg_wr && reg_addr == `JPC_REG_RUNTIME_EN) begin
    run_en_q <= reg_wdata[`JPC_RUNTIME_EN_BIT];
  end
end

// three sources ored; blank part enables by default
wire port_on = nvm_dedicate | run_en_q | port_select_term
  | blank_device;
// device reset only stops the port when nvm does not dedicate it
wire dev_block = !rst_n_s && !nvm_dedicate;
wire tap_hold = !port_on || dev_block;

////////////////////////////////////////////////////////////////////////
// clock edge detect on the synchronised test clock
reg tck_q;
always @(posedge sys_clk) begin
  if (!nrst) begin
    tck_q <= 1'b0;
  end else begin
    tck_q <= tck;
  end
end
wire tck_rise = tck && !tck_q;
wire tck_fall = !tck && tck_q;

////////////////////////////////////////////////////////////////////////
// tap controller and shift registers
reg [15:0] st_q;
reg [`JPC_IR_W-1:0] ir_sh_q;
reg [`JPC_IR_W-1:0] ir_q;
reg [`JPC_DR_W-1:0] dr_q;
reg bypass_q;
reg tdo_q;
always @(posedge sys_clk) begin
  if (!nrst || tap_hold) begin
    st_q <= S_RESET;
    ir_sh_q <= `JPC_IR_BYPASS;
    dr_q <= {`JPC_DR_W{1'b0}};
    bypass_q <= 1'b0;
  end else if (tck_rise) begin
    st_q <= tap_next(st_q, tms);
    case (st_q)
      S_CIR: ir_sh_q <= 4'h1;
      S_SHIR: ir_sh_q <= {tdi, ir_sh_q[`JPC_IR_W-1:1]};
      // capture loads read data; secured reads return zero
      S_CDR: dr_q <= {14'h0000, security_bit ? 8'h00 : flash_rdata};
      S_SHDR: begin
        dr_q <= {tdi, dr_q[`JPC_DR_W-1:1]};
        bypass_q <= tdi;
      end
      default: ir_sh_q <= ir_sh_q;
    endcase
  end
end

// instruction register, bypass after tap reset
always @(posedge sys_clk) begin
  if (!nrst || tap_hold) begin
    ir_q <= `JPC_IR_BYPASS;
  end else if (tck_rise && st_q == S_RESET) begin
    ir_q <= `JPC_IR_BYPASS;
  end else if (tck_rise && st_q == S_UIR) begin
    ir_q <= ir_sh_q; // only isc codes decode; no boundary scan
  end
end

// output data changes on the falling test clock
always @(posedge sys_clk) begin
  if (!nrst) begin
    tdo_q <= 1'b0;
  end else if (tck_fall) begin
    if (st_q == S_SHIR) begin
      tdo_q <= ir_sh_q[0];
    end else if (ir_q == `JPC_IR_BYPASS) begin
      tdo_q <= bypass_q;
    end else begin
      tdo_q <= dr_q[0];
    end
  end
end

////////////////////////////////////////////////////////////////////////
// command execution at update of the data register
wire upd = tck_rise && st_q == S_UDR;
wire [1:0] d_op = dr_q[21:20];
wire [3:0] d_sec = dr_q[19:16];
reg isc_on_q; // enable command received; drives data out
reg ext_q;
reg od_q;
reg disabled_q; // disable seen; next device reset clears error
reg err_q;
reg busy_q;
wire sec_prot = (d_sec < NSEC) ? sector_protect[d_sec] : 1'b0;
reg refuse;
always @* begin
  refuse = 1'b0;
  case (ir_q)
    `JPC_IR_PROGRAM, `JPC_IR_READ, `JPC_IR_VERIFY: begin
      refuse = security_bit;
    end
    `JPC_IR_ERASE: begin
      refuse = security_bit || sec_prot;
    end
    default: refuse = 1'b0;
  endcase
end

always @(posedge sys_clk) begin
  if (!nrst || tap_hold) begin
    isc_on_q <= 1'b0;
    ext_q <= 1'b0;
    od_q <= 1'b0;
  end else if (upd && ir_q == `JPC_IR_ENABLE) begin
    isc_on_q <= 1'b1;
    ext_q <= dr_q[`JPC_OPT_EXT];
    od_q <= dr_q[`JPC_OPT_OD];
  end else if (upd && ir_q == `JPC_IR_DISABLE) begin
    isc_on_q <= 1'b0;
    ext_q <= 1'b0;
    od_q <= 1'b0;
  end
end

// flash request pulses; chip erase also drops security
always @(posedge sys_clk) begin
  if (!nrst) begin
    flash_req <= 1'b0;
    flash_op <= OP_READ;
    flash_sector <= 4'h0;
    flash_addr <= 8'h00;
    flash_wdata <= 8'h00;
    clear_security <= 1'b0;
    cmd_refused <= 1'b0;
  end else begin
    flash_req <= 1'b0;
    clear_security <= 1'b0;
    cmd_refused <= upd && isc_on_q && refuse;
    if (upd && isc_on_q && !refuse) begin
      case (ir_q)
        `JPC_IR_PROGRAM: begin
          flash_req <= 1'b1;
          flash_op <= (d_op == OP_ERASE) ? OP_PROG : d_op;
        end
        `JPC_IR_ERASE: begin
          flash_req <= 1'b1;
          flash_op <= OP_ERASE;
        end
        `JPC_IR_READ, `JPC_IR_VERIFY: begin
          flash_req <= 1'b1;
          flash_op <= OP_READ;
        end
        `JPC_IR_CHIP_ERASE: begin
          flash_req <= 1'b1;
          flash_op <= OP_CHIP;
          clear_security <= 1'b1;
        end
        default: flash_req <= 1'b0;
      endcase
      flash_sector <= d_sec;
      flash_addr <= dr_q[15:8];
      flash_wdata <= dr_q[7:0];
    end
  end
end

////////////////////////////////////////////////////////////////////////
// sticky error flag; a new fail wins over the clear
always @(posedge sys_clk) begin
  if (!nrst) begin
    err_q <= 1'b0;
    disabled_q <= 1'b0;
  end else begin
    if (upd && ir_q == `JPC_IR_DISABLE) begin
      disabled_q <= 1'b1;
    end else if (upd && ir_q == `JPC_IR_ENABLE) begin
      disabled_q <= 1'b0;
    end else if (!rst_n_s) begin
      disabled_q <= 1'b0;
    end
    if (flash_fail) begin
      err_q <= 1'b1;
    end else if (upd && ir_q == `JPC_IR_CLEAR) begin
      err_q <= 1'b0;
    end else if (!rst_n_s && disabled_q) begin
      err_q <= 1'b0;
    end
  end
end

// busy mirrors ready/busy of both arrays
always @(posedge sys_clk) begin
  if (!nrst) begin
    busy_q <= 1'b0;
  end else begin
    busy_q <= flash_busy || flash2_writing;
  end
end

////////////////////////////////////////////////////////////////////////
// pin drive; open-drain only ever drives low
always @(posedge sys_clk) begin
  if (!nrst) begin
    port_c_out <= 7'h00;
    port_c_oe <= 7'h00;
    port_owned <= 1'b0;
  end else begin
    port_owned <= port_on;
    port_c_out <= 7'h00;
    port_c_oe <= 7'h00;
    port_c_out[`JPC_PC_DOUT] <= tdo_q;
    port_c_oe[`JPC_PC_DOUT] <= port_on && isc_on_q;
    if (port_on && ext_q) begin
      port_c_out[`JPC_PC_STAT] <= !busy_q;
      port_c_oe[`JPC_PC_STAT] <= od_q ? busy_q : 1'b1;
      port_c_out[`JPC_PC_ERR] <= !err_q;
      port_c_oe[`JPC_PC_ERR] <= od_q ? err_q : 1'b1;
    end // otherwise extension pins left undriven
  end
end

// register read back shows enable bit
always @(posedge sys_clk) begin
  if (!nrst) begin
    reg_rdata <= `JPC_RUNTIME_EN_RST;
  end else if (reg_addr == `JPC_REG_RUNTIME_EN) begin
    reg_rdata <= {7'h00, run_en_q};
  end else begin
    reg_rdata <= 8'h00;
  end
end
endmodule
`default_nettype wire

// *** rtl/jpc_sync2.v ***
`timescale 1ns/1ps
`default_nettype none
module jpc_sync2 #(
  parameter W = 1
) (
  input wire sys_clk,
  input wire nrst,
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);
reg [W-1:0] meta_q;
// first stage is read only by the second stage
always @(posedge sys_clk) begin
  if (!nrst) begin
    meta_q <= {W{1'b0}};
    sync_out <= {W{1'b0}};
  end else begin
    meta_q <= async_in;
    sync_out <= meta_q;
  end
end
endmodule
`default_nettype wire

// *** shared/jpc_map.vh ***
`ifndef JPC_MAP_VH
`define JPC_MAP_VH
// runtime enable register, offset above the io block base
`define JPC_REG_RUNTIME_EN 8'hC7
`define JPC_RUNTIME_EN_BIT 0
`define JPC_RUNTIME_EN_RST 8'h00
// port c bit positions
`define JPC_PC_MODE 0
`define JPC_PC_CLK 1
`define JPC_PC_STAT 3
`define JPC_PC_ERR 4
`define JPC_PC_DIN 5
`define JPC_PC_DOUT 6
// instruction codes (4 bit shift register)
`define JPC_IR_W 4
`define JPC_IR_BYPASS 4'hF
`define JPC_IR_ENABLE 4'h1
`define JPC_IR_DISABLE 4'h2
`define JPC_IR_CLEAR 4'h3
`define JPC_IR_PROGRAM 4'h4
`define JPC_IR_ERASE 4'h5
`define JPC_IR_READ 4'h6
`define JPC_IR_VERIFY 4'h7
`define JPC_IR_CHIP_ERASE 4'h8
// data register width: op(2) sector(4) addr(8) data(8)
`define JPC_DR_W 22
// enable option bits in the data register after an enable command
`define JPC_OPT_EXT 0
`define JPC_OPT_OD 1
// tap states, one-hot
`define JPC_TAP_W 16
`endif
